/* verilog/power_mode_rate_select.sv */
// power mode and output rate selection for accelerometer and gyroscope
`timescale 1ns/1ns
module power_mode_rate_select
    import pm_pkg::*;
#(
    parameter int BOOT_LEN = BOOT_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // sensor samples
    input wire logic [15:0] accel_sample_i,
    input wire logic [15:0] gyro_sample_i,
    // decoded state
    output logic [2:0] accel_mode_o,
    output logic [2:0] gyro_mode_o,
    output logic [3:0] accel_rate_o,
    output logic [3:0] gyro_rate_o,
    output logic boot_done_o,
    output logic accel_tick_o,
    output logic gyro_tick_o
);
    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    logic [7:0] accel_control_one, gyro_control_one, common_control_four;
    logic [7:0] common_control_five, common_control_six, gyro_control_seven;
    logic [15:0] accel_data, gyro_data;
    logic [7:0] trim_sum;
    state_e state;
    logic [31:0] boot_cnt;
    trim_if tif ();
    trim_mem u_trim (.clk_i(clk_i), .port(tif));

    wire [3:0] accel_rate_code = accel_control_one[RATE_LSB +: 4];
    wire [3:0] gyro_rate_code = gyro_control_one[RATE_LSB +: 4];
    wire gyro_sleep = common_control_four[SLEEP_BIT];
    wire accel_ultralow_enable = common_control_five[ULP_BIT];
    wire accel_highperf_disable = common_control_six[HPD_BIT];
    wire gyro_highperf_disable = gyro_control_seven[HPD_BIT];
    wire running = (state == ST_RUN);

    // ------------------------------------------------------------------------
    // boot sequence
    // ------------------------------------------------------------------------
    wire boot_last = (boot_cnt == 32'(BOOT_LEN - 1));
    assign tif.addr = boot_cnt[3:0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_BOOT;
            boot_cnt <= '0;
            trim_sum <= '0;
        end else if (state == ST_BOOT) begin
            boot_cnt <= boot_cnt + 32'd1;
            if (boot_cnt < 32'd17) begin
                trim_sum <= trim_sum + tif.rdata;
            end
            if (boot_last) begin
                state <= ST_RUN;
            end
        end
    end

    // ------------------------------------------------------------------------
    // accelerometer decode
    // ------------------------------------------------------------------------
    wire a_off = (accel_rate_code == CODE_OFF) || (accel_rate_code > CODE_1P6);
    wire a_code_b = (accel_rate_code == CODE_1P6);
    wire a_ulp_cfg = accel_ultralow_enable && !accel_highperf_disable;
    wire a_bad_cfg = accel_ultralow_enable && accel_highperf_disable;
    wire a_ulp_na = a_ulp_cfg && (accel_rate_code > CODE_208) && !a_code_b;
    wire a_is_off = !running || a_off || a_bad_cfg || a_ulp_na;
    wire [3:0] a_idx_raw = a_code_b ? IDX_1P6 : 4'(accel_rate_code + 4'd1);
    wire [3:0] next_accel_rate = a_is_off ? IDX_OFF :
        (a_code_b && !a_ulp_cfg && !accel_highperf_disable) ? IDX_12P5 : a_idx_raw;
    mode_e next_accel_mode;
    assign next_accel_mode = a_is_off ? MODE_OFF :
        a_ulp_cfg ? MODE_ULP :
        !accel_highperf_disable ? MODE_HP :
        (a_code_b || accel_rate_code <= CODE_52) ? MODE_LP :
        (accel_rate_code <= CODE_208) ? MODE_NORMAL : MODE_HP;

    // ------------------------------------------------------------------------
    // gyroscope decode
    // ------------------------------------------------------------------------
    wire g_is_off = !running || gyro_rate_code == CODE_OFF ||
        gyro_rate_code > CODE_MAX;
    wire [3:0] next_gyro_rate = g_is_off ? IDX_OFF : 4'(gyro_rate_code + 4'd1);
    mode_e next_gyro_mode;
    assign next_gyro_mode = g_is_off ? MODE_OFF :
        gyro_sleep ? MODE_SLEEP :
        !gyro_highperf_disable ? MODE_HP :
        (gyro_rate_code <= CODE_52) ? MODE_LP :
        (gyro_rate_code <= CODE_208) ? MODE_NORMAL : MODE_HP;

    // ------------------------------------------------------------------------
    // sample timebase: rate index k ticks every 2^(11-k) base ticks
    // ------------------------------------------------------------------------
    logic [15:0] base_cnt;
    logic [10:0] div_cnt;
    wire base_tick = (base_cnt == 16'(BASE_TICK_CYCLES - 1));
    wire g_active = (gyro_mode_o != MODE_OFF) && (gyro_mode_o != MODE_SLEEP);
    wire a_active = (accel_mode_o != MODE_OFF);
    wire [3:0] a_sh = 4'd11 - accel_rate_o;
    wire [3:0] g_sh = 4'd11 - gyro_rate_o;
    wire [10:0] a_mask = 11'((12'd1 << a_sh) - 12'd1);
    wire [10:0] g_mask = 11'((12'd1 << g_sh) - 12'd1);
    // one shared divider keeps both rates power-of-two related and aligned
    wire next_accel_tick = a_active && base_tick && ((div_cnt & a_mask) == '0);
    wire next_gyro_tick = g_active && base_tick && ((div_cnt & g_mask) == '0);
    always_ff @(posedge clk_i) begin
        if (rst_i || !running) begin
            base_cnt <= '0;
            div_cnt <= '0;
        end else begin
            base_cnt <= base_tick ? '0 : base_cnt + 16'd1;
            if (base_tick) begin
                div_cnt <= div_cnt + 11'd1;
            end
        end
    end

    // ------------------------------------------------------------------------
    // outputs and data hold
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            accel_mode_o <= MODE_OFF;
            gyro_mode_o <= MODE_OFF;
            accel_rate_o <= IDX_OFF;
            gyro_rate_o <= IDX_OFF;
            boot_done_o <= 1'b0;
            accel_tick_o <= 1'b0;
            gyro_tick_o <= 1'b0;
            accel_data <= '0;
            gyro_data <= '0;
        end else begin
            accel_mode_o <= next_accel_mode;
            gyro_mode_o <= next_gyro_mode;
            accel_rate_o <= next_accel_rate;
            gyro_rate_o <= next_gyro_rate;
            boot_done_o <= running;
            accel_tick_o <= next_accel_tick;
            gyro_tick_o <= next_gyro_tick;
            if (next_accel_tick) begin
                accel_data <= accel_sample_i;
            end
            if (next_gyro_tick) begin
                gyro_data <= gyro_sample_i;
            end
        end
    end

    // ------------------------------------------------------------------------
    // wishbone slave: one registered ack cycle per access, one wait state
    // ------------------------------------------------------------------------
    wire req = cyc_i && stb_i && !ack_o;
    // a write lands on the edge at which the master samples ack high
    wire wr = cyc_i && stb_i && ack_o && we_i && sel_i[0];
    logic [31:0] next_dat;
    always_comb begin
        unique case (adr_i)
            ADDR_ACCEL_CONTROL_ONE: next_dat = {24'h0, accel_control_one};
            ADDR_GYRO_CONTROL_ONE: next_dat = {24'h0, gyro_control_one};
            ADDR_COMMON_CONTROL_FOUR: next_dat = {24'h0, common_control_four};
            ADDR_COMMON_CONTROL_FIVE: next_dat = {24'h0, common_control_five};
            ADDR_COMMON_CONTROL_SIX: next_dat = {24'h0, common_control_six};
            ADDR_GYRO_CONTROL_SEVEN: next_dat = {24'h0, gyro_control_seven};
            ADDR_STATUS: next_dat = {16'h0, trim_sum, 1'b0, gyro_mode_o, accel_mode_o, running};
            ADDR_ACCEL_DATA: next_dat = {16'h0, accel_data};
            ADDR_GYRO_DATA: next_dat = {16'h0, gyro_data};
            default: next_dat = 32'h0;
        endcase
    end
    // registers stay writable in every mode; boot does not clear them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= '0;
            accel_control_one <= CTRL_RESET;
            gyro_control_one <= CTRL_RESET;
            common_control_four <= CTRL_RESET;
            common_control_five <= CTRL_RESET;
            common_control_six <= CTRL_RESET;
            gyro_control_seven <= CTRL_RESET;
        end else begin
            ack_o <= req;
            dat_o <= req ? next_dat : 32'h0;
            if (wr && adr_i == ADDR_ACCEL_CONTROL_ONE) accel_control_one <= dat_i[7:0];
            if (wr && adr_i == ADDR_GYRO_CONTROL_ONE) gyro_control_one <= dat_i[7:0];
            if (wr && adr_i == ADDR_COMMON_CONTROL_FOUR) common_control_four <= dat_i[7:0];
            if (wr && adr_i == ADDR_COMMON_CONTROL_FIVE) common_control_five <= dat_i[7:0];
            if (wr && adr_i == ADDR_COMMON_CONTROL_SIX) common_control_six <= dat_i[7:0];
            if (wr && adr_i == ADDR_GYRO_CONTROL_SEVEN) gyro_control_seven <= dat_i[7:0];
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    AST_BOOT_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
        !running |=> accel_mode_o == MODE_OFF && gyro_mode_o == MODE_OFF)
        else $error("sensor active during boot");
    AST_CODE0: assert property (@(posedge clk_i) disable iff (rst_i)
        accel_rate_code == CODE_OFF |=> accel_mode_o == MODE_OFF)
        else $error("accel code zero not off");
    AST_ULP_NA: assert property (@(posedge clk_i) disable iff (rst_i)
        a_ulp_cfg && accel_rate_code == 4'h7 |=> accel_mode_o == MODE_OFF)
        else $error("ulp unavailable code ran");
    AST_LP: assert property (@(posedge clk_i) disable iff (rst_i)
        running && !accel_ultralow_enable && accel_highperf_disable && accel_rate_code == 4'h2
        |=> accel_mode_o == MODE_LP && accel_rate_o == 4'h3)
        else $error("accel low power decode wrong");
    AST_HP12: assert property (@(posedge clk_i) disable iff (rst_i)
        running && !accel_ultralow_enable && !accel_highperf_disable && a_code_b
        |=> accel_mode_o == MODE_HP && accel_rate_o == IDX_12P5)
        else $error("code 1011 not 12.5 hp");
    AST_GYRO_NORM: assert property (@(posedge clk_i) disable iff (rst_i)
        running && !gyro_sleep && gyro_highperf_disable && gyro_rate_code == CODE_104
        |=> gyro_mode_o == MODE_NORMAL)
        else $error("gyro normal decode wrong");
    AST_SLEEP: assert property (@(posedge clk_i) disable iff (rst_i)
        running && gyro_sleep && gyro_rate_code != CODE_OFF && gyro_rate_code <= CODE_MAX
        |=> gyro_mode_o == MODE_SLEEP)
        else $error("gyro sleep ignored");
    AST_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
        accel_mode_o == MODE_OFF |=> $stable(accel_data))
        else $error("accel data changed in power down");
    AST_SYNC: assert property (@(posedge clk_i) disable iff (rst_i)
        next_gyro_tick && a_active && accel_rate_o >= gyro_rate_o |-> next_accel_tick)
        else $error("accel not aligned to gyro");
    AST_BOOTLEN: assert property (@(posedge clk_i) disable iff (rst_i)
        !running |-> boot_cnt < 32'(BOOT_LEN))
        else $error("boot too long");
endmodule : power_mode_rate_select

/* verilog/pm_pkg.sv */
// constants, types and functional notes for the power mode and rate select block
// ----------------------------------------------------------------------------
// Functional notes
// - boot loads trim, at most 10 ms
// - after boot both sensors power down
// - accel-only, gyro-only or both active
// - accel five modes, gyro five, independent
// - both on: accel rate synced to gyro
// - accel mode from code, ulp, hp-disable
// - ulp table: six rates, 0110-1010 unavailable
// - hp-disable table: low-power, normal, high-perf
// - hp enabled, ulp off: codes 0001-1011 high-perf
// - gyro mode from code and hp-disable
// - gyro sleep alternative to power-down
// - sleep bit overrides gyro rate codes 0001-1010 only
// - power-down keeps bus, config, holds data
// ----------------------------------------------------------------------------
package pm_pkg;
    // -------------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int BOOT_MS = 10;
    localparam int BOOT_CYCLES = CLK_HZ / 1000 * BOOT_MS;
    // clock cycles per base 6.66 kHz tick, the period of the fastest rate index
    localparam int BASE_TICK_CYCLES = CLK_HZ / 6660;
    // -------------------------------------------------------------------------
    // register offsets (byte addresses)
    // -------------------------------------------------------------------------
    localparam logic [7:0] ADDR_ACCEL_CONTROL_ONE = 8'h00;
    localparam logic [7:0] ADDR_GYRO_CONTROL_ONE = 8'h04;
    localparam logic [7:0] ADDR_COMMON_CONTROL_FOUR = 8'h08;
    localparam logic [7:0] ADDR_COMMON_CONTROL_FIVE = 8'h0C;
    localparam logic [7:0] ADDR_COMMON_CONTROL_SIX = 8'h10;
    localparam logic [7:0] ADDR_GYRO_CONTROL_SEVEN = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_ACCEL_DATA = 8'h1C;
    localparam logic [7:0] ADDR_GYRO_DATA = 8'h20;
    // -------------------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------------------
    localparam int RATE_LSB = 4;
    localparam int SLEEP_BIT = 6;
    localparam int ULP_BIT = 7;
    localparam int HPD_BIT = 4;
    localparam int AUXSPI_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] CODE_OFF = 4'h0;
    localparam logic [3:0] CODE_1P6 = 4'hB;
    localparam logic [3:0] CODE_208 = 4'h5;
    localparam logic [3:0] CODE_104 = 4'h4;
    localparam logic [3:0] CODE_52 = 4'h3;
    localparam logic [3:0] CODE_MAX = 4'hA;
    // rate index: 0 off, 1 1.6, 2 12.5 .. 11 6.66k
    localparam logic [3:0] IDX_OFF = 4'h0;
    localparam logic [3:0] IDX_1P6 = 4'h1;
    localparam logic [3:0] IDX_12P5 = 4'h2;
    // -------------------------------------------------------------------------
    // modes
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_OFF, MODE_ULP, MODE_LP, MODE_NORMAL, MODE_HP, MODE_SLEEP
    } mode_e;
    typedef enum logic [1:0] {ST_BOOT, ST_RUN} state_e;
endpackage : pm_pkg

/* verilog/trim_if.sv */
// interface between the control block and the trim memory
`timescale 1ns/1ns
interface trim_if;
    logic [3:0] addr;
    logic [7:0] rdata;
    modport ctrl (output addr, input rdata);
    modport mem (input addr, output rdata);
endinterface : trim_if

/* verilog/trim_mem.sv */
// trim parameter memory with registered read data
`timescale 1ns/1ns
module trim_mem
    import pm_pkg::*;
(
    input wire logic clk_i,
    trim_if.mem port
);
    logic [7:0] mem [16];
    logic [7:0] rdata_q;
    // ------------------------------------------------------------------------
    // fixed trim contents
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < 16; i++) begin : g_trim
        assign mem[i] = 8'(i * 8'h11);
    end
    always_ff @(posedge clk_i) begin
        rdata_q <= mem[port.addr];
    end
    assign port.rdata = rdata_q;
endmodule : trim_mem

/* verif/wb_host.sv */
// host model: wishbone classic master that configures the sensor block
`timescale 1ns/1ns
module wb_host (
    // clock
    input wire logic clk_i,
    // wishbone master
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    input wire logic ack_i,
    input wire logic [31:0] dat_i
);
    // ------------------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------------------
    // the host never selects an auxiliary spi connection mode
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    task automatic cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                         input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
    endtask : cycle

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        cycle(1'b1, a, d, s, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        cycle(1'b0, a, 32'h0, 4'hF, q);
    endtask : rd
endmodule : wb_host

/* verif/testbench.sv */
// self-checking testbench for the power mode and rate select block
`timescale 1ns/1ns
module testbench;
    import pm_pkg::*;
    localparam int BOOT = 40;
    localparam int LIMIT = 40000;
    logic clk_i, rst_i, cyc, stb, we, ack;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] accel_sample_i, gyro_sample_i;
    logic [2:0] accel_mode_o, gyro_mode_o;
    logic [3:0] accel_rate_o, gyro_rate_o;
    logic boot_done_o, accel_tick_o, gyro_tick_o;
    logic [6:0] e;
    int mismatches, checks, n, a_t, stray;
    int cycles = 0;

    power_mode_rate_select #(.BOOT_LEN(BOOT)) power_mode_rate_select_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .accel_sample_i(accel_sample_i), .gyro_sample_i(gyro_sample_i),
        .accel_mode_o(accel_mode_o), .gyro_mode_o(gyro_mode_o),
        .accel_rate_o(accel_rate_o), .gyro_rate_o(gyro_rate_o),
        .boot_done_o(boot_done_o), .accel_tick_o(accel_tick_o), .gyro_tick_o(gyro_tick_o));
    wb_host wb_host_inst (
        .clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .ack_i(ack), .dat_i(rdat));

    // ------------------------------------------------------------------------
    // expected decode
    // ------------------------------------------------------------------------
    function automatic logic [6:0] acc_exp(input logic [3:0] c, input logic u, input logic h);
        logic [3:0] r;
        r = (c == 4'hB) ? 4'h1 : c + 4'h1;
        if (c == 4'h0 || c > 4'hB || (u && h)) return 7'h00;
        if (u) return (c > 4'h5 && c != 4'hB) ? 7'h00 : {MODE_ULP, r};
        if (!h) return {MODE_HP, (c == 4'hB) ? 4'h2 : r};
        return {(c == 4'hB || c < 4'h4) ? MODE_LP : (c < 4'h6 ? MODE_NORMAL : MODE_HP), r};
    endfunction : acc_exp

    function automatic logic [6:0] gyr_exp(input logic [3:0] c, input logic h);
        if (c == 4'h0 || c > 4'hA) return 7'h00;
        if (!h) return {MODE_HP, c + 4'h1};
        return {c < 4'h4 ? MODE_LP : (c < 4'h6 ? MODE_NORMAL : MODE_HP), c + 4'h1};
    endfunction : gyr_exp

    // ------------------------------------------------------------------------
    // compares and report
    // ------------------------------------------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_mode(input logic [2:0] got, input logic [2:0] exp);
        check_word({29'h0, got}, {29'h0, exp});
    endtask : check_mode

    task automatic results;
        $display("mismatches %0d checks %0d", mismatches, checks);
        if (mismatches == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    task automatic settle;
        repeat (2) @(posedge clk_i);
        #1;
    endtask : settle

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            results();
        end
    end

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        accel_sample_i = 16'h0;
        gyro_sample_i = 16'h0;
        mismatches = 0;
        checks = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        #1;
        check_word({31'h0, boot_done_o}, 32'h0);
        n = 0;
        while (boot_done_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check_word({31'h0, boot_done_o}, 32'h1);
        check_word({26'h0, accel_mode_o, gyro_mode_o}, 32'h0);
        // accel table: power down before each ultralow change
        for (int u = 0; u < 4; u++) begin
            wb_host_inst.wr(ADDR_ACCEL_CONTROL_ONE, 32'h0, 4'hF);
            wb_host_inst.wr(ADDR_COMMON_CONTROL_FIVE, {24'h0, u < 2, 7'h0}, 4'hF);
            wb_host_inst.wr(ADDR_COMMON_CONTROL_SIX, {27'h0, u == 1 || u == 2, 4'h0}, 4'hF);
            for (int c = 0; c < 16; c++) begin
                wb_host_inst.wr(ADDR_ACCEL_CONTROL_ONE, {24'h0, 4'(c), 4'h0}, 4'hF);
                settle();
                e = acc_exp(4'(c), u < 2, u == 1 || u == 2);
                check_mode(accel_mode_o, e[6:4]);
                check_word({28'h0, accel_rate_o}, {28'h0, e[3:0]});
            end
        end
        for (int h = 0; h < 2; h++) begin
            wb_host_inst.wr(ADDR_GYRO_CONTROL_SEVEN, {27'h0, h == 1, 4'h0}, 4'hF);
            for (int c = 0; c < 16; c++) begin
                wb_host_inst.wr(ADDR_GYRO_CONTROL_ONE, {24'h0, 4'(c), 4'h0}, 4'hF);
                settle();
                e = gyr_exp(4'(c), h == 1);
                check_mode(gyro_mode_o, e[6:4]);
                check_word({28'h0, gyro_rate_o}, {28'h0, e[3:0]});
            end
        end
        wb_host_inst.wr(ADDR_GYRO_CONTROL_ONE, 32'h40, 4'hF);
        wb_host_inst.wr(ADDR_COMMON_CONTROL_FOUR, 32'h40, 4'hF);
        settle();
        check_mode(gyro_mode_o, MODE_SLEEP);
        wb_host_inst.rd(ADDR_STATUS, q);
        check_word({16'h0, q[15:0]}, 32'hF851);
        wb_host_inst.wr(ADDR_GYRO_CONTROL_ONE, 32'h0, 4'hF);
        settle();
        check_mode(gyro_mode_o, MODE_OFF);
        wb_host_inst.wr(ADDR_COMMON_CONTROL_FOUR, 32'h0, 4'hF);
        // capture, then hold in power-down
        gyro_sample_i <= 16'h1234;
        accel_sample_i <= 16'hBEEF;
        wb_host_inst.wr(ADDR_GYRO_CONTROL_ONE, 32'hA0, 4'hF);
        n = 0;
        while (gyro_tick_o !== 1'b1 && n < 4000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        check_word({31'h0, gyro_tick_o}, 32'h1);
        wb_host_inst.wr(ADDR_GYRO_CONTROL_ONE, 32'h0, 4'hF);
        wb_host_inst.wr(ADDR_ACCEL_CONTROL_ONE, 32'h30, 4'hF);
        gyro_sample_i <= 16'h5678;
        repeat (3500) @(posedge clk_i);
        wb_host_inst.wr(ADDR_GYRO_DATA, 32'hFFFF, 4'hF);
        wb_host_inst.rd(ADDR_GYRO_DATA, q);
        check_word(q, 32'h1234);
        wb_host_inst.wr(ADDR_ACCEL_CONTROL_ONE, 32'hA0, 4'hE);
        wb_host_inst.rd(ADDR_ACCEL_CONTROL_ONE, q);
        check_word({24'h0, q[7:0]}, 32'h30);
        wb_host_inst.wr(8'h40, 32'hFF, 4'hF);
        wb_host_inst.rd(8'h40, q);
        check_word(q, 32'h0);
        // both sensors on: accel ticks only on gyro ticks
        wb_host_inst.wr(ADDR_ACCEL_CONTROL_ONE, 32'h90, 4'hF);
        wb_host_inst.wr(ADDR_GYRO_CONTROL_ONE, 32'hA0, 4'hF);
        a_t = 0;
        stray = 0;
        repeat (7000) begin
            @(posedge clk_i);
            #1;
            if (accel_tick_o === 1'b1) a_t++;
            if (accel_tick_o === 1'b1 && gyro_tick_o !== 1'b1) stray++;
        end
        check_word(32'(stray), 32'h0);
        check_word({31'h0, a_t > 0}, 32'h1);
        wb_host_inst.rd(ADDR_ACCEL_DATA, q);
        check_word(q, 32'hBEEF);
        results();
    end
endmodule : testbench
